// ===== design/data_move_pkg.sv
// Package of constants and carrier types for the data-move instruction unit
package data_move_pkg;
    localparam int DATA_W = 8;
    localparam int WORD_W = 16;
    // Data-space addresses of core registers seen by this unit
    localparam logic [7:0] ADDR_INDF0 = 8'h00;
    localparam logic [7:0] ADDR_INDF1 = 8'h08;
    localparam logic [7:0] ADDR_WORKING_ACCUMULATOR = 8'h0A;
    localparam logic [7:0] ADDR_BSR = 8'h0F;
    localparam logic [7:0] ADDR_FSR0 = 8'h01;
    localparam logic [7:0] ADDR_FSR1 = 8'h09;
    // Opcode patterns
    localparam logic [2:0] OP_FILE_TO_PERIPH = 3'h3;
    localparam logic [2:0] OP_PERIPH_TO_FILE = 3'h2;
    localparam logic [7:0] OP_LOAD_LIT = 8'hB0;
    localparam logic [7:0] OP_BANK_LOW = 8'hB8;
    localparam logic [6:0] OP_BANK_HIGH = 7'h5D;
    localparam logic [7:0] RST_BYTE = 8'h00;
    // Instruction word field positions
    localparam int OPC_MSB = 15;
    localparam int OPC_GRP_LSB = 13;
    localparam int OPC_BYTE_LSB = 8;
    localparam int OPC_BHI_LSB = 9;
    localparam int P_MSB = 12;
    localparam int P_LSB = 8;
    localparam int P_W = 5;
    localparam int F_MSB = 7;
    localparam int NIB_W = 4;

    typedef enum logic [1:0] {Q1, Q2, Q3, Q4} qphase_t;
    typedef enum logic [2:0] {K_NONE, K_F2P, K_P2F, K_LIT, K_BLO, K_BHI} kind_t;

    // Data memory request towards the partner
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } mem_req_t;

    typedef struct packed {
        qphase_t phase;
        kind_t kind;
        logic [7:0] src;
        logic [7:0] dst;
        logic [7:0] lit;
        logic [7:0] data;
        logic [7:0] working_accumulator;
        logic [7:0] bank_select_reg;
        logic [7:0] fsr0;
        logic [7:0] fsr1;
        logic zflag;
        logic cyc_done;
        mem_req_t req;
    } state_t;
endpackage : data_move_pkg

// ===== design/data_move_instruction_unit.sv
// Quarter-cycle executor for the data-move instruction group
//
// Behaviour
// - The file-to-peripheral move copies the byte at address f into address p and leaves the flags alone.
// - The f operand is 8 bits over the whole data space and the p operand 5 bits over 00h to 1Fh.
// - The working accumulator may be either operand of both file/peripheral moves.
// - Indirect addressing is resolved separately on the f and on the p operand.
// - Each instruction is one word and one cycle: Q1 decode, Q2 read, Q3 process, Q4 write.
// - The bank low load writes the literal into bits 3:0 of the bank select register only.
// - The bank high load writes the literal into bits 7:4 of the bank select register only.
// - The literal load puts the 8-bit literal into the working accumulator, flags untouched.
// - The peripheral-to-file move copies the byte at address p into address f and updates zero.
`timescale 1ns/100ps
module data_move_instruction_unit (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic instr_valid_in,
    input wire logic [data_move_pkg::WORD_W-1:0] instr_in,
    input wire logic [data_move_pkg::DATA_W-1:0] mem_rdata_in,
    output data_move_pkg::mem_req_t mem_req_out,
    output logic [data_move_pkg::DATA_W-1:0] working_accumulator_out,
    output logic [data_move_pkg::DATA_W-1:0] bank_select_reg_out,
    output logic zero_flag_out,
    output data_move_pkg::qphase_t phase_out,
    output logic instr_done_out
);
    import data_move_pkg::*;

    state_t s_q;
    state_t s_d;

    ////////////////////////////////////////////////////////////////////////
    // The field split and the nibble loads only make sense for these widths,
    // so anything else is refused before the logic is ever built
    if (DATA_W != 8) begin : g_bad_data_w
        $error("data width must be 8");
    end
    if (WORD_W != 16) begin : g_bad_word_w
        $error("instruction word width must be 16");
    end
    if (2 * NIB_W != DATA_W) begin : g_bad_nibble
        $error("nibble width must be half the data width");
    end
    if (P_W != P_MSB - P_LSB + 1) begin : g_bad_p_field
        $error("p field width and position disagree");
    end

    ////////////////////////////////////////////////////////////////////////
    // Opcode decode; the don't-care bits of the bank loads are never looked at,
    // so any filler the assembler leaves there still decodes
    function automatic kind_t decode_kind(input logic [WORD_W-1:0] w);
        if (w[OPC_MSB:OPC_GRP_LSB] == OP_FILE_TO_PERIPH) begin
            decode_kind = K_F2P;
        end else if (w[OPC_MSB:OPC_GRP_LSB] == OP_PERIPH_TO_FILE) begin
            decode_kind = K_P2F;
        end else if (w[OPC_MSB:OPC_BYTE_LSB] == OP_LOAD_LIT) begin
            decode_kind = K_LIT;
        end else if (w[OPC_MSB:OPC_BYTE_LSB] == OP_BANK_LOW) begin
            decode_kind = K_BLO;
        end else if (w[OPC_MSB:OPC_BHI_LSB] == OP_BANK_HIGH) begin
            decode_kind = K_BHI;
        end else begin
            decode_kind = K_NONE;
        end
    endfunction : decode_kind

    // Both file/peripheral moves share the read-then-write path
    function automatic logic is_move(input kind_t k);
        is_move = (k == K_F2P) || (k == K_P2F);
    endfunction : is_move

    // Indirect slots map to the matching pointer; others pass through.
    // Only one level is resolved: a pointer aimed at an indirect slot is
    // taken as a plain address, which avoids an endless chain.
    function automatic logic [7:0] resolve(input logic [7:0] a, input logic [7:0] p0,
                                           input logic [7:0] p1);
        if (a == ADDR_INDF0) begin
            resolve = p0;
        end else if (a == ADDR_INDF1) begin
            resolve = p1;
        end else begin
            resolve = a;
        end
    endfunction : resolve

    // Core registers held here are read locally, the rest go to data memory
    function automatic logic is_local(input logic [7:0] a);
        is_local = (a == ADDR_WORKING_ACCUMULATOR) || (a == ADDR_BSR) || (a == ADDR_FSR0) || (a == ADDR_FSR1);
    endfunction : is_local

    ////////////////////////////////////////////////////////////////////////
    // Next state: one instruction walks Q1..Q4, the phase free-runs
    always_comb begin
        logic [7:0] fa;
        logic [7:0] pa;
        fa = '0;
        pa = '0;
        s_d = s_q;
        s_d.req.rd = 1'b0;
        s_d.req.wr = 1'b0;
        s_d.cyc_done = 1'b0;
        case (s_q.phase)
            Q1: begin
                // Decode; pointers as they stand now apply to both operands,
                // so a move that rewrites a pointer only affects later words
                s_d.phase = Q2;
                fa = resolve(instr_in[F_MSB:0], s_q.fsr0, s_q.fsr1);
                pa = resolve({{(DATA_W - P_W){1'b0}}, instr_in[P_MSB:P_LSB]},
                             s_q.fsr0, s_q.fsr1);
                s_d.lit = instr_in[F_MSB:0];
                s_d.kind = instr_valid_in ? decode_kind(instr_in) : K_NONE;
                if (s_d.kind == K_F2P) begin
                    s_d.src = fa;
                    s_d.dst = pa;
                end else if (s_d.kind == K_P2F) begin
                    s_d.src = pa;
                    s_d.dst = fa;
                end
                // Local registers never reach the bus, which keeps the memory
                // from seeing strobes for addresses it does not own
                if (is_move(s_d.kind)) begin
                    s_d.req.rd = !is_local(s_d.src);
                    s_d.req.addr = s_d.src;
                end
            end
            Q2: begin
                // Source read: local registers or the memory answer
                s_d.phase = Q3;
                case (s_q.src)
                    ADDR_WORKING_ACCUMULATOR: s_d.data = s_q.working_accumulator;
                    ADDR_BSR: s_d.data = s_q.bank_select_reg;
                    ADDR_FSR0: s_d.data = s_q.fsr0;
                    ADDR_FSR1: s_d.data = s_q.fsr1;
                    default: s_d.data = mem_rdata_in;
                endcase
                if (s_q.kind == K_LIT || s_q.kind == K_BLO || s_q.kind == K_BHI) begin
                    s_d.data = s_q.lit;
                end
            end
            Q3: begin
                // Process: only the upward move touches zero
                s_d.phase = Q4;
                if (s_q.kind == K_P2F) begin
                    s_d.zflag = (s_q.data == RST_BYTE);
                end
                if (is_move(s_q.kind) && !is_local(s_q.dst)) begin
                    s_d.req.wr = 1'b1;
                    s_d.req.addr = s_q.dst;
                    s_d.req.wdata = s_q.data;
                end
            end
            Q4: begin
                // Destination write
                s_d.phase = Q1;
                s_d.cyc_done = (s_q.kind != K_NONE);
                case (s_q.kind)
                    K_F2P, K_P2F: begin
                        case (s_q.dst)
                            ADDR_WORKING_ACCUMULATOR: s_d.working_accumulator = s_q.data;
                            ADDR_BSR: s_d.bank_select_reg = s_q.data;
                            ADDR_FSR0: s_d.fsr0 = s_q.data;
                            ADDR_FSR1: s_d.fsr1 = s_q.data;
                            default: s_d.working_accumulator = s_q.working_accumulator;
                        endcase
                    end
                    K_LIT: s_d.working_accumulator = s_q.data;
                    K_BLO: s_d.bank_select_reg = {s_q.bank_select_reg[DATA_W-1:NIB_W], s_q.data[NIB_W-1:0]};
                    K_BHI: s_d.bank_select_reg = {s_q.data[DATA_W-1:NIB_W], s_q.bank_select_reg[NIB_W-1:0]};
                    default: s_d.working_accumulator = s_q.working_accumulator;
                endcase
            end
            default: s_d.phase = Q1;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // State register; reset parks the core at Q1 with clear registers
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            s_q <= '0;
            s_q.phase <= Q1;
            s_q.kind <= K_NONE;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from the state flops
    assign mem_req_out = s_q.req;
    assign working_accumulator_out = s_q.working_accumulator;
    assign bank_select_reg_out = s_q.bank_select_reg;
    assign zero_flag_out = s_q.zflag;
    assign phase_out = s_q.phase;
    assign instr_done_out = s_q.cyc_done;
endmodule : data_move_instruction_unit

// ===== sim/data_move_properties.sv
// Port-level properties of the data-move instruction unit
`timescale 1ns/100ps
module data_move_properties import data_move_pkg::*; (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic instr_valid_in,
    input wire logic [data_move_pkg::WORD_W-1:0] instr_in,
    input wire logic [data_move_pkg::DATA_W-1:0] mem_rdata_in,
    input wire data_move_pkg::mem_req_t mem_req_out,
    input wire logic [data_move_pkg::DATA_W-1:0] working_accumulator_out,
    input wire logic [data_move_pkg::DATA_W-1:0] bank_select_reg_out,
    input wire logic zero_flag_out,
    input wire data_move_pkg::qphase_t phase_out,
    input wire logic instr_done_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    // Decode only counts in Q1, so the load and copy checks start from there
    wire take = instr_valid_in && phase_out == Q1;
    a_phase_wraps: assert property (phase_out == Q4 |=> phase_out == Q1)
        else $error("phase did not wrap to Q1");
    a_read_in_q2: assert property (mem_req_out.rd |-> phase_out == Q2 ##1 !mem_req_out.rd)
        else $error("read strobe outside Q2");
    a_write_in_q4: assert property (mem_req_out.wr |-> phase_out == Q4 ##1 !mem_req_out.wr)
        else $error("write strobe outside Q4");
    a_done_after_q4: assert property (instr_done_out |-> $past(phase_out) == Q4)
        else $error("done pulse misplaced");
    a_bank_low_load: assert property (take && instr_in[15:8] == OP_BANK_LOW |-> ##4
        bank_select_reg_out == {$past(bank_select_reg_out[7:4], 4), $past(instr_in[3:0], 4)})
        else $error("bank low nibble load wrong");
    a_bank_high_load: assert property (take && instr_in[15:9] == OP_BANK_HIGH |-> ##4
        bank_select_reg_out == {$past(instr_in[7:4], 4), $past(bank_select_reg_out[3:0], 4)})
        else $error("bank high nibble load wrong");
    a_literal_load: assert property (take && instr_in[15:8] == OP_LOAD_LIT |-> ##4
        working_accumulator_out == $past(instr_in[7:0], 4) &&
        zero_flag_out == $past(zero_flag_out, 4))
        else $error("literal load wrong");
    a_copy_keeps_zero: assert property (take && instr_in[15:13] == OP_FILE_TO_PERIPH |->
        ##4 instr_done_out && zero_flag_out == $past(zero_flag_out, 4))
        else $error("file to peripheral copy touched zero flag");
endmodule : data_move_properties
bind data_move_instruction_unit data_move_properties i_props (.clk_in(clk_in), .rst_in(rst_in),
    .instr_valid_in(instr_valid_in), .instr_in(instr_in), .mem_rdata_in(mem_rdata_in),
    .mem_req_out(mem_req_out), .working_accumulator_out(working_accumulator_out),
    .bank_select_reg_out(bank_select_reg_out), .zero_flag_out(zero_flag_out),
    .phase_out(phase_out), .instr_done_out(instr_done_out));

// ===== sim/data_mem_model.sv
// Zero-latency data memory standing in for the core data space
`timescale 1ns/100ps
module data_mem_model import data_move_pkg::*; (
    input wire logic clk_in,
    input wire data_move_pkg::mem_req_t req_in,
    output logic [7:0] rdata_out
);
    logic [7:0] mem_q [256];
    logic [7:0] last_q = 8'h00;
    initial for (int i = 0; i < 256; i++) mem_q[i] = 8'(i) ^ 8'h5A;
    // Idle bus shows the inverse of the last byte, so a late sample is caught
    always_comb rdata_out = req_in.rd ? mem_q[req_in.addr] : ~last_q;
    always @(posedge clk_in) begin
        if (req_in.rd) last_q <= mem_q[req_in.addr];
        if (req_in.wr) mem_q[req_in.addr] <= req_in.wdata;
    end
endmodule : data_mem_model

// ===== sim/tb_top.sv
// Self-checking bench for the data-move instruction unit
`timescale 1ns/100ps
module tb_top;
    import data_move_pkg::*;
    logic clk_in = 0, rst_in = 1, instr_valid_in = 0, z = 0, z_o, done;
    logic [15:0] instr_in = 16'h0000, x;
    logic [7:0] rdata, w_o, b_o, w = 0, b = 0, f0 = 0, f1 = 0, m [256];
    logic [15:0] wq [$];
    logic [16:0] dq [$];
    logic [15:0] prog [15] = '{16'hB05A, 16'hB8F5, 16'hBB3F, 16'hBA20, 16'h750A, 16'hB000,
        16'h760A, 16'h5640, 16'h520A, 16'h5101, 16'h7300, 16'h5409, 16'h6820, 16'h6800,
        16'hB335};
    mem_req_t req;
    qphase_t ph;
    int num_errors = 0, check_count = 0, seed = 32'h1f37, r;
    data_move_instruction_unit i_dut (.clk_in(clk_in), .rst_in(rst_in),
        .instr_valid_in(instr_valid_in), .instr_in(instr_in), .mem_rdata_in(rdata),
        .mem_req_out(req), .working_accumulator_out(w_o), .bank_select_reg_out(b_o),
        .zero_flag_out(z_o), .phase_out(ph), .instr_done_out(done));
    data_mem_model i_mem (.clk_in(clk_in), .req_in(req), .rdata_out(rdata));
    initial forever #25 clk_in = ~clk_in;
    task end_sim;
        if (num_errors == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : end_sim
    task chk(input logic [39:0] seen, input logic [39:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    ////////////////////////////////////////////////////////////////
    // Reference: pointers resolve one level, local registers never reach the bus
    function logic [7:0] res(input logic [7:0] a);
        return a == ADDR_INDF0 ? f0 : a == ADDR_INDF1 ? f1 : a;
    endfunction : res
    function logic [7:0] get(input logic [7:0] a);
        case (res(a))
            ADDR_WORKING_ACCUMULATOR: return w;
            ADDR_BSR: return b;
            ADDR_FSR0: return f0;
            ADDR_FSR1: return f1;
            default: return m[res(a)];
        endcase
    endfunction : get
    task put(input logic [7:0] a, input logic [7:0] d);
        case (res(a))
            ADDR_WORKING_ACCUMULATOR: w = d;
            ADDR_BSR: b = d;
            ADDR_FSR0: f0 = d;
            ADDR_FSR1: f1 = d;
            default: begin m[res(a)] = d; wq.push_back({res(a), d}); end
        endcase
    endtask : put
    // Present one word in Q1 and note what it must produce
    task run(input logic [15:0] v);
        for (int n = 0; ph !== Q4; n++) begin
            if (n > 8) begin
                chk(1, 0);
                end_sim();
            end
            @(posedge clk_in);
        end
        instr_valid_in <= 1;
        instr_in <= v;
        casez (v)
            16'b011?????????????: put({3'h0, v[12:8]}, get(v[7:0]));
            16'b010?????????????: begin x[7:0] = get({3'h0, v[12:8]}); z = x[7:0] == 0; put(v[7:0], x[7:0]); end
            16'hB0??: w = v[7:0];
            16'hB8??: b[3:0] = v[3:0];
            16'b1011101?????????: b[7:4] = v[7:4];
            default: v = 0;
        endcase
        if (v != 0) dq.push_back({w, b, z});
        @(posedge clk_in);
        instr_valid_in <= 0;
    endtask : run
    // Results are matched against notes in the order they were made
    always @(posedge clk_in) if (!rst_in) begin
        if (req.wr === 1'b1) chk({req.addr, req.wdata}, wq.size() ? wq.pop_front() : 'x);
        if (done === 1'b1) chk({w_o, b_o, z_o}, dq.size() ? dq.pop_front() : 'x);
    end
    initial begin
        for (int i = 0; i < 256; i++) m[i] = 8'(i) ^ 8'h5A;
        repeat (2) @(posedge clk_in);
        rst_in <= 0;
        @(posedge clk_in);
        chk({w_o, b_o, z_o, req}, 0);
        foreach (prog[k]) run(prog[k]);
        repeat (40) begin
            r = $random(seed);
            run(r[15] ? {8'hB0, r[7:0]} : {2'b01, r[12], 1'b1, r[11:8], r[7:0] | 8'h10});
        end
        repeat (8) @(posedge clk_in);
        chk(wq.size() + dq.size(), 0);
        end_sim();
    end
endmodule : tb_top
